// ===== shared/mute_select_defs.vh
// Constants for the audio mute input source selection block
// Behaviour
// RL1: Port 1 register bits 2:0 hold a read/write selector, reset zero.
// RL2: Port 2 register holds an identical selector, reset zero, same code table.
// RL3: Code 000 drives the port mute input with constant zero.
// RL4: Code 001 routes port 0 serializer 7 / second serial clock pin.
// RL5: Code 010 routes serializer 8 / port 1 serializer 5 / second serial slave-out.
// RL6: Code 011 routes serializer 9 / port 1 serializer 4 / second serial slave-in.
// RL7: Code 100 routes the port 2 receive high-frequency clock pin.
// RL8: Code 101 routes the first serial interface slave-in pin.
// RL9: Code 110 routes first serial chip select / second two-wire clock pin.
// RL10: Code 111 routes first serial enable / second two-wire data pin.
// RL11: Bits 31:3 reserved; read any value, software writes zeros only.
// RL12: Without port 2, its register is reserved and has no effect.
// RL13: Registered selector drives the mux; new choice acts after write completes.
`ifndef MUTE_SELECT_DEFS_VH
`define MUTE_SELECT_DEFS_VH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define PORT1_MUTE_CFG_ADDR 32'h4000001c
`define PORT2_MUTE_CFG_ADDR 32'h40000020

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SEL_MSB 2
`define SEL_LSB 0
`define SEL_WIDTH 3
`define SEL_RESET 3'h0

// ----------------------------------------
// Selector codes
// ----------------------------------------
`define SEL_ZERO 3'h0
`define SEL_SER7 3'h1
`define SEL_SER8 3'h2
`define SEL_SER9 3'h3
`define SEL_HCLK 3'h4
`define SEL_SIMO0 3'h5
`define SEL_CS0 3'h6
`define SEL_ENA0 3'h7

`endif

// ===== hw/pin_sync.v
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module pin_sync
#(
    parameter WIDTH = 7
)
(
    input wire clock,
    input wire reset_n,
    input wire [WIDTH-1:0] pinsIn,
    output wire [WIDTH-1:0] pinsSync
);
    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;

    // First stage is read only by the second stage
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1_reg <= {WIDTH{1'b0}};
            stage2_reg <= {WIDTH{1'b0}};
        end
        else
        begin
            stage1_reg <= pinsIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign pinsSync = stage2_reg;
endmodule

// ===== hw/mute_source_mux.v
// Eight-way mute source multiplexer driven by a selector code
`timescale 1ns/1ps
`include "mute_select_defs.vh"
module mute_source_mux
(
    input wire [2:0] sel,
    input wire [6:0] sources,
    output reg muteOut
);
    // Code zero gives constant low; others pick one synchronised pin
    always @*
    begin
        case (sel)
            `SEL_ZERO: muteOut = 1'b0; // RL3
            `SEL_SER7: muteOut = sources[0]; // RL4
            `SEL_SER8: muteOut = sources[1]; // RL5
            `SEL_SER9: muteOut = sources[2]; // RL6
            `SEL_HCLK: muteOut = sources[3]; // RL7
            `SEL_SIMO0: muteOut = sources[4]; // RL8
            `SEL_CS0: muteOut = sources[5]; // RL9
            `SEL_ENA0: muteOut = sources[6]; // RL10
            default: muteOut = 1'b0;
        endcase
    end
endmodule

// ===== hw/audio_mute_input_select.v
// APB register block choosing the mute input source of audio ports 1 and 2
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "mute_select_defs.vh"
module audio_mute_input_select
#(
    parameter HAS_PORT2 = 1
)
(
    input wire clock,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire port0_serializer7_pin,
    input wire port0_serializer8_pin,
    input wire port0_serializer9_pin,
    input wire port2_rx_high_clock_pin,
    input wire first_serial_if_slave_in_pin,
    input wire first_serial_if_chip_select_pin,
    input wire first_serial_if_enable_pin,
    output reg port1MuteIn,
    output reg port2MuteIn
);
    // ----------------------------------------
    // Registers and wires
    // ----------------------------------------
    // Response phase codes; the access phase follows setup by one edge
    localparam PHASE_IDLE = 1'b0;
    localparam PHASE_ACCESS = 1'b1;

    // Response path state and its next values
    reg phase_reg;
    reg phase_next;
    reg pready_next;
    reg pslverr_next;
    reg [31:0] prdata_next;

    // Read-back word and address-hit flag of the current setup cycle
    reg [31:0] rdata_next;
    reg hit_next;

    // Selector values of both ports, as seen by the read-back path
    wire [2:0] port1Sel;
    wire [2:0] port2Sel;

    // Raw and synchronised pin bundles
    wire [6:0] pinsRaw;
    wire [6:0] pinsSync;

    // Bus decode
    wire setupPhase;
    wire hitPort1;
    wire hitPort2;
    wire accessDone;
    wire writeDone;

    // Per-lane vectors; lane 0 is port 1, lane 1 is port 2
    wire [1:0] hitVec;
    wire [1:0] portPresent;
    wire [5:0] selBank;
    wire [1:0] muxVec;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Bit order follows the selector codes 001 to 111, lowest bit first
    assign pinsRaw = {first_serial_if_enable_pin, first_serial_if_chip_select_pin,
        first_serial_if_slave_in_pin, port2_rx_high_clock_pin,
        port0_serializer9_pin, port0_serializer8_pin, port0_serializer7_pin};

    // Pins come from outside the clock domain; the fast receive clock
    // is only sampled, so treat it as a slow level indicator.
    // Both ports share one synchroniser bank to save flops.
    pin_sync #(.WIDTH(7)) syncPins
    (
        .clock(clock),
        .reset_n(reset_n),
        .pinsIn(pinsRaw),
        .pinsSync(pinsSync)
    );

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    // Full 32-bit compare; aliases of the two words are refused
    assign setupPhase = psel & ~penable;
    assign hitPort1 = (paddr == `PORT1_MUTE_CFG_ADDR);
    assign hitPort2 = (paddr == `PORT2_MUTE_CFG_ADDR) && (HAS_PORT2 != 0); // RL12

    // A write lands only at the edge that completes the access
    assign accessDone = psel & penable & pready;
    assign writeDone = accessDone & pwrite;

    // Address hits and port presence, indexed by lane
    assign hitVec = {hitPort2, hitPort1};
    assign portPresent = {(HAS_PORT2 != 0), 1'b1}; // RL12

    // Read data; reserved bits read as zero
    always @*
    begin
        rdata_next = 32'h00000000;
        hit_next = 1'b1;
        if (hitPort1)
            rdata_next[`SEL_MSB:`SEL_LSB] = port1Sel; // RL1
        else if (hitPort2)
            rdata_next[`SEL_MSB:`SEL_LSB] = port2Sel; // RL2
        else
            hit_next = 1'b0;
    end

    // ----------------------------------------
    // Response phase machine
    // ----------------------------------------
    // No wait state: pready rises in the first access cycle, so the
    // transfer completes at the second edge after setup. The answer is
    // fixed, so a master never waits longer than that.
    always @*
    begin
        phase_next = PHASE_IDLE;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        prdata_next = 32'h00000000;
        case (phase_reg)
            PHASE_IDLE:
            begin
                if (setupPhase)
                begin
                    phase_next = PHASE_ACCESS;
                    pready_next = 1'b1;
                    pslverr_next = ~hit_next; // RL12
                    prdata_next = pwrite ? 32'h00000000 : rdata_next;
                end
            end
            PHASE_ACCESS:
            begin
                // Completing edge; a back-to-back setup is seen next cycle
                phase_next = PHASE_IDLE;
            end
            default:
            begin
                phase_next = PHASE_IDLE;
            end
        endcase
    end

    // Response flops; answer outputs stand for the access cycle only
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phase_reg <= PHASE_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            phase_reg <= phase_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
            prdata <= prdata_next;
        end
    end

    // ----------------------------------------
    // Selector lanes
    // ----------------------------------------
    // One lane per port: selector register and its multiplexer. Upper
    // write bits are dropped, since software must keep them zero anyway.
    // An absent port never takes a write and its mux output is forced low.
    genvar lane;
    generate
        for (lane = 0; lane < 2; lane = lane + 1)
        begin : portLane
            reg [2:0] laneSel_reg;
            reg [2:0] laneSel_next;
            wire laneWrite;
            wire laneMux;

            // Write strobe for this lane only
            assign laneWrite = writeDone & hitVec[lane] & portPresent[lane];

            // Hold the selector unless this lane is written
            always @*
            begin
                laneSel_next = laneSel_reg;
                if (laneWrite)
                    laneSel_next = pwdata[`SEL_MSB:`SEL_LSB]; // RL1 RL2 RL11
            end

            // Selector storage; both lanes leave reset at code zero
            always @(posedge clock or negedge reset_n)
            begin
                if (!reset_n)
                    laneSel_reg <= `SEL_RESET; // RL1 RL2
                else
                    laneSel_reg <= laneSel_next; // RL13
            end

            // Same code table for both lanes
            mute_source_mux laneMuxInst
            (
                .sel(laneSel_reg),
                .sources(pinsSync),
                .muteOut(laneMux)
            );

            // Lane results into the shared vectors
            assign selBank[3 * lane + 2:3 * lane] = laneSel_reg;
            assign muxVec[lane] = laneMux & portPresent[lane]; // RL12
        end
    endgenerate

    // Selector values handed to the read-back path
    assign port1Sel = selBank[2:0];
    assign port2Sel = selBank[5:3];

    // ----------------------------------------
    // Mute outputs
    // ----------------------------------------
    // Registered outputs: one edge after the selector, so a new
    // choice shows at the edge after the write completes
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            port1MuteIn <= 1'b0;
            port2MuteIn <= 1'b0;
        end
        else
        begin
            port1MuteIn <= muxVec[0]; // RL13
            port2MuteIn <= muxVec[1]; // RL12 RL13
        end
    end
endmodule

// ===== verification/audio_mute_input_select_sva.sv
// Assertion checker for the audio mute input select block
`timescale 1ns/1ps
`include "mute_select_defs.vh"
module audio_mute_input_select_sva
#(
    parameter HAS_PORT2 = 1
)
(
    input wire clock,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire pready,
    input wire pslverr,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire port1MuteIn,
    input wire port2MuteIn
);
    wire hit1 = paddr == `PORT1_MUTE_CFG_ADDR;
    wire hit2 = HAS_PORT2 != 0 && paddr == `PORT2_MUTE_CFG_ADDR;
    wire done = psel && penable && pready;
    reg [2:0] sel1Reg, sel2Reg;

    // Shadow selectors, updated only on a completed write
    always @(posedge clock or negedge reset_n)
        if (!reset_n)
            {sel1Reg, sel2Reg} <= 6'h00;
        else if (done && pwrite)
            {sel1Reg, sel2Reg} <= {hit1 ? pwdata[2:0] : sel1Reg, hit2 ? pwdata[2:0] : sel2Reg};

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    ack_next_a: assert property (psel && !penable |=> pready) else $error("late ack");
    ack_once_a: assert property (pready |=> !pready) else $error("long ack");
    err_map_a: assert property (pready |-> pslverr == !(hit1 || hit2)) else $error("bad err");
    rd_resv_a: assert property (pready && !pwrite |-> prdata[31:3] == 0) else $error("resv");
    rd_one_a: assert property (pready && !pwrite && hit1 |-> prdata[2:0] == sel1Reg)
        else $error("bad sel1");
    rd_two_a: assert property (pready && !pwrite && hit2 |-> prdata[2:0] == sel2Reg)
        else $error("bad sel2");
    zero_one_a: assert property ($past(sel1Reg) == 0 |-> !port1MuteIn) else $error("mute1");
    zero_two_a: assert property ($past(sel2Reg) == 0 |-> !port2MuteIn) else $error("mute2");
    cover property (done && pwrite && hit2);
    cover property (done && pslverr);
    cover property (sel1Reg == 3'h7);
endmodule

bind audio_mute_input_select audio_mute_input_select_sva #(.HAS_PORT2(HAS_PORT2))
    u_audio_mute_input_select_sva (.*);

// ===== verification/mute_pin_source.sv
// Behavioural driver of the seven shared pins
`timescale 1ns/1ps
module mute_pin_source
(
    input wire clock,
    input wire [6:0] pattern,
    output reg [6:0] pins
);
    // Pins move after the edge, as pads fed from elsewhere would
    always @(posedge clock)
        pins <= pattern;
endmodule

// ===== verification/audio_mute_input_select_tb.sv
// Self-checking bench for the audio mute input select block
`timescale 1ns/1ps
`include "mute_select_defs.vh"
module audio_mute_input_select_tb;
    logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic pready, pslverr, port1MuteIn, port2MuteIn;
    logic [6:0] pattern = 0;
    wire [6:0] pins;
    int num_errors = 0, n_tests = 0;

    audio_mute_input_select u_audio_mute_input_select (.*,
        .port0_serializer7_pin(pins[0]), .port0_serializer8_pin(pins[1]),
        .port0_serializer9_pin(pins[2]), .port2_rx_high_clock_pin(pins[3]),
        .first_serial_if_slave_in_pin(pins[4]), .first_serial_if_chip_select_pin(pins[5]),
        .first_serial_if_enable_pin(pins[6]));
    mute_pin_source u_mute_pin_source (.*);

    // 25 MHz clock
    initial
        forever #20 clock = ~clock;

    // One APB transfer; an idle cycle after it avoids double drives
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            num_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        if (num_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Both selectors leave reset at code zero
    task automatic reset_values;
        xfer(0, `PORT1_MUTE_CFG_ADDR, 0);
        check(rd, 0);
        xfer(0, `PORT2_MUTE_CFG_ADDR, 0);
        check(rd, 0);
    endtask

    // Every code on both ports, port 2 walking the table backwards
    task automatic route_codes;
        logic [6:0] pat;
        for (int c = 0; c < 8; c++)
        begin
            xfer(1, `PORT1_MUTE_CFG_ADDR, c);
            xfer(1, `PORT2_MUTE_CFG_ADDR, 7 - c);
            xfer(0, `PORT2_MUTE_CFG_ADDR, 0);
            check(rd, 7 - c);
            for (int p = 0; p < 2; p++)
            begin
                pat = p ? 7'h01 << (6 - c) : 7'h7f;
                pattern <= pat;
                repeat (6) @(posedge clock);
                check(port1MuteIn, c != 0 && pat[c - 1]);
                check(port2MuteIn, c != 7 && pat[6 - c]);
            end
        end
    endtask

    // Unmapped word is refused and the selector survives
    task automatic unmapped_access;
        xfer(1, `PORT2_MUTE_CFG_ADDR + 4, 3);
        check(err, 1);
        xfer(0, `PORT1_MUTE_CFG_ADDR, 0);
        check(rd, 7);
    endtask

    // Main sequence
    initial
    begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        reset_values;
        route_codes;
        unmapped_access;
        final_report;
    end

    // Watchdog against a hung handshake
    initial
    begin
        repeat (3000) @(posedge clock);
        num_errors++;
        final_report;
    end
endmodule
